/* File: hw/bpt_regs.svh */
// Register indices, field positions and reset values of the breakpoint and array test unit.
// Assumes it is included by bare name from the design and the testbench.
`ifndef BPT_REGS_SVH
`define BPT_REGS_SVH

`define BPT_SEL_ADDR0 4'h0
`define BPT_SEL_ADDR1 4'h1
`define BPT_SEL_ADDR2 4'h2
`define BPT_SEL_ADDR3 4'h3
`define BPT_SEL_STATUS 4'h6
`define BPT_SEL_CONTROL 4'h7
`define BPT_SEL_CDATA 4'h8
`define BPT_SEL_CTAG 4'h9
`define BPT_SEL_CCTRL 4'ha
`define BPT_SEL_TCMD 4'hb
`define BPT_SEL_TDATA 4'hc

`define BPT_STATUS_RST 32'hffff0ff0
`define BPT_STATUS_FIXED 32'hffff0ff0
`define BPT_CONTROL_RST 32'h00000400
`define BPT_CONTROL_FIXED 32'h00000400
`define BPT_CONTROL_MASK 32'hffff23ff
`define BPT_ZERO32 32'h00000000

`define BPT_ST_SSTEP 14
`define BPT_ST_TSW 15
`define BPT_CT_LOCK 13
`define BPT_CT_FIELDS 16

`define BPT_RW_EXEC 2'h0
`define BPT_RW_WRITE 2'h1
`define BPT_RW_RDWR 2'h3
`define BPT_LEN_1 2'h0
`define BPT_LEN_2 2'h1
`define BPT_LEN_4 2'h3

`define BPT_T_CMD 0
`define BPT_T_VALID 11
`define BPT_T_DIRTY 9
`define BPT_T_USER 7
`define BPT_T_WRIT 5
`define BPT_T_CD 11
`define BPT_T_WT 10
`define BPT_T_LRU 7
`define BPT_T_HIT 4
`define BPT_T_SET 2

`define BPT_C_DATA 10
`define BPT_C_TAG 9
`define BPT_C_REC 7
`define BPT_C_BV 3
`define BPT_C_LINE 4
`define BPT_C_SET 2
`define BPT_C_OP 0
`define BPT_COP_NONE 2'h0
`define BPT_COP_WRITE 2'h1
`define BPT_COP_READ 2'h2
`define BPT_COP_FLUSH 2'h3

`endif

/* File: hw/bpt_pkg.sv */
// Types shared by the breakpoint and array test unit.
// Assumes nothing beyond a SystemVerilog compiler.
package bpt_pkg;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [1:0] size;
        logic write;
        logic exec;
    } bpt_access_t;

    typedef struct packed {
        logic valid;
        logic [19:0] lin;
        logic dirty;
        logic user;
        logic writable;
        logic [19:0] phys;
        logic cd;
        logic wt;
    } bpt_tlb_ent_t;

    typedef struct packed {
        logic [22:0] tag;
        logic [31:0] data;
        logic [3:0] bvalid;
    } bpt_cline_t;

    typedef enum logic [1:0] {
        BPT_IDLE = 2'b00,
        BPT_EXEC = 2'b01,
        BPT_TRAP = 2'b11
    } bpt_state_t;

endpackage

/* File: hw/bpt_unit.sv */
// Breakpoint comparators, debug status and control, translation buffer and cache test access.
// Assumes the core presents register moves on the sel/wr/rd port and access events on the same clock.
`include "bpt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bpt_unit #(
    parameter int TLB_SETS = 4,
    parameter int TLB_ROWS = 8,
    parameter int CACHE_LINES = 128
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // Register move port
    input wire logic [3:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Core events
    input wire bpt_pkg::bpt_access_t access,
    input wire logic insn_done,
    input wire logic trap_flag,
    input wire logic task_switch,
    input wire logic task_trap_bit,
    input wire logic direct_mapped,
    // Exception request and access lock
    output logic debug_exc,
    output logic debug_access_lock
);

    initial begin
        if (TLB_SETS != 4 || TLB_ROWS != 8 || CACHE_LINES != 128)
            $error("bpt_unit: geometry not supported");
    end

    logic [31:0] bp_addr_q [4];
    logic [31:0] control_q;
    logic [31:0] status_q;
    logic [31:0] tcmd_q;
    logic [31:0] tdata_q;
    logic [31:0] cdata_q;
    logic [31:0] ctag_q;
    logic [31:0] cctrl_q;
    bpt_pkg::bpt_tlb_ent_t tlb_q [TLB_SETS*TLB_ROWS];
    logic [2:0] plru_q [TLB_ROWS];
    bpt_pkg::bpt_cline_t cache_q [2*CACHE_LINES];
    logic recent_q [CACHE_LINES];
    bpt_pkg::bpt_state_t state_q;

    // Byte-range overlap against one breakpoint
    function automatic logic bp_match(input logic [31:0] bpa, input logic [1:0] rw, input logic [1:0] len,
                                      input bpt_pkg::bpt_access_t a);
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] bhi;
        logic type_ok;
        lo = bpa;
        unique case (len)
            `BPT_LEN_2: lo = {bpa[31:1], 1'b0};
            `BPT_LEN_4: lo = {bpa[31:2], 2'b00};
            default: lo = bpa;
        endcase
        bhi = (len == `BPT_LEN_4) ? lo + 32'h3 : (len == `BPT_LEN_2) ? lo + 32'h1 : lo;
        hi = a.addr + {30'h0, a.size};
        unique case (rw)
            `BPT_RW_EXEC: type_ok = a.exec;
            `BPT_RW_WRITE: type_ok = a.write && !a.exec;
            `BPT_RW_RDWR: type_ok = !a.exec;
            default: type_ok = 1'b0;
        endcase
        bp_match = a.valid && type_ok && (a.addr <= bhi) && (hi >= lo) && (len != 2'h2);
    endfunction

    // Attribute pair test
    function automatic logic pair_ok(input logic [1:0] p, input logic b);
        pair_ok = (p == 2'h3) || (p == 2'h2 && b) || (p == 2'h1 && !b);
    endfunction

    logic [3:0] bp_hit;
    logic [3:0] bp_en;
    logic bp_fire;
    logic step_fire;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bp_hit[i] = bp_match(bp_addr_q[i], control_q[`BPT_CT_FIELDS+4*i +: 2],
                                 control_q[`BPT_CT_FIELDS+4*i+2 +: 2], access);
            bp_en[i] = control_q[2*i] | control_q[2*i+1];
        end
    end
    assign bp_fire = |(bp_hit & bp_en);
    assign step_fire = insn_done && trap_flag;
    assign debug_exc = clk_en && (bp_fire || step_fire);
    assign debug_access_lock = control_q[`BPT_CT_LOCK];

    // Exception sequencing state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= bpt_pkg::BPT_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                bpt_pkg::BPT_IDLE: state_q <= access.valid ? bpt_pkg::BPT_EXEC : bpt_pkg::BPT_IDLE;
                bpt_pkg::BPT_EXEC: state_q <= debug_exc ? bpt_pkg::BPT_TRAP : bpt_pkg::BPT_IDLE;
                bpt_pkg::BPT_TRAP: state_q <= bpt_pkg::BPT_IDLE;
                default: state_q <= bpt_pkg::BPT_IDLE;
            endcase
        end
    end

    // Breakpoint addresses
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++)
                bp_addr_q[i] <= `BPT_ZERO32;
        end else if (clk_en && reg_wr && reg_sel <= `BPT_SEL_ADDR3) begin
            bp_addr_q[reg_sel[1:0]] <= reg_wdata;
        end
    end

    // Breakpoint control
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            control_q <= `BPT_CONTROL_RST;
        end else if (clk_en) begin
            if (reg_wr && reg_sel == `BPT_SEL_CONTROL)
                control_q <= (reg_wdata & `BPT_CONTROL_MASK) | `BPT_CONTROL_FIXED;
            if (task_switch) begin
                for (int i = 0; i < 4; i++)
                    control_q[2*i] <= 1'b0;
            end
            if (debug_exc)
                control_q[`BPT_CT_LOCK] <= 1'b0;
        end
    end

    // Debug status: set-only by hardware, software rewrites it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_q <= `BPT_STATUS_RST;
        end else if (clk_en) begin
            if (reg_wr && reg_sel == `BPT_SEL_STATUS)
                status_q <= (reg_wdata & ~`BPT_STATUS_FIXED) | `BPT_STATUS_FIXED;
            if (debug_exc) begin
                status_q[3:0] <= status_q[3:0] | bp_hit;
                if (step_fire)
                    status_q[`BPT_ST_SSTEP] <= 1'b1;
            end
            if (task_switch && task_trap_bit)
                status_q[`BPT_ST_TSW] <= 1'b1;
        end
    end

    // Translation buffer test
    logic [4:0] t_idx [TLB_SETS];
    logic [TLB_SETS-1:0] t_match;
    logic [1:0] t_hit_set;
    logic [1:0] t_repl_set;
    logic [1:0] t_wset;
    always_comb begin
        t_hit_set = 2'h0;
        for (int s = 0; s < TLB_SETS; s++) begin
            t_idx[s] = {s[1:0], tcmd_q[14:12]};
            t_match[s] = tlb_q[t_idx[s]].valid && tlb_q[t_idx[s]].lin == tcmd_q[31:12]
                && pair_ok(tcmd_q[`BPT_T_DIRTY +: 2], tlb_q[t_idx[s]].dirty)
                && pair_ok(tcmd_q[`BPT_T_USER +: 2], tlb_q[t_idx[s]].user)
                && pair_ok(tcmd_q[`BPT_T_WRIT +: 2], tlb_q[t_idx[s]].writable);
            if (t_match[s])
                t_hit_set = s[1:0];
        end
        t_repl_set = !plru_q[tcmd_q[14:12]][0] ? {1'b0, plru_q[tcmd_q[14:12]][1]}
                                               : {1'b1, plru_q[tcmd_q[14:12]][2]};
        t_wset = reg_wdata[`BPT_T_HIT] ? reg_wdata[`BPT_T_SET +: 2] : t_repl_set;
    end
    logic t_one;
    assign t_one = $onehot(t_match);
    bpt_pkg::bpt_tlb_ent_t t_hit_ent;
    assign t_hit_ent = tlb_q[t_idx[t_hit_set]];
    logic t_look_q;

    // Lookup runs once, in the cycle after the command write
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            t_look_q <= 1'b0;
        end else if (clk_en) begin
            t_look_q <= reg_wr && reg_sel == `BPT_SEL_TCMD && reg_wdata[`BPT_T_CMD];
        end
    end

    // Lookup fires on command write with command bit set; buffer write fires on data write with it clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tcmd_q <= `BPT_ZERO32;
        end else if (clk_en && reg_wr && reg_sel == `BPT_SEL_TCMD) begin
            tcmd_q <= reg_wdata;
        end else if (clk_en && t_look_q && t_one) begin
            tcmd_q[`BPT_T_VALID] <= 1'b1;
            tcmd_q[`BPT_T_DIRTY +: 2] <= {t_hit_ent.dirty, ~t_hit_ent.dirty};
            tcmd_q[`BPT_T_USER +: 2] <= {t_hit_ent.user, ~t_hit_ent.user};
            tcmd_q[`BPT_T_WRIT +: 2] <= {t_hit_ent.writable, ~t_hit_ent.writable};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tdata_q <= `BPT_ZERO32;
        end else if (clk_en) begin
            if (reg_wr && reg_sel == `BPT_SEL_TDATA) begin
                tdata_q <= reg_wdata;
            end else if (tcmd_q[`BPT_T_CMD] && state_q == bpt_pkg::BPT_IDLE && reg_wr
                         && reg_sel == `BPT_SEL_TCMD) begin
                tdata_q[`BPT_T_HIT] <= 1'b0;
            end else if (t_look_q && t_one) begin
                tdata_q[31:12] <= tlb_q[t_idx[t_hit_set]].phys;
                tdata_q[`BPT_T_CD] <= tlb_q[t_idx[t_hit_set]].cd;
                tdata_q[`BPT_T_WT] <= tlb_q[t_idx[t_hit_set]].wt;
                tdata_q[`BPT_T_LRU +: 3] <= plru_q[tcmd_q[14:12]];
                tdata_q[`BPT_T_HIT] <= 1'b1;
                tdata_q[`BPT_T_SET +: 2] <= t_hit_set;
            end else if (t_look_q) begin
                tdata_q[`BPT_T_HIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int e = 0; e < TLB_SETS*TLB_ROWS; e++)
                tlb_q[e] <= '0;
            for (int r = 0; r < TLB_ROWS; r++)
                plru_q[r] <= 3'h0;
        end else if (clk_en && reg_wr && reg_sel == `BPT_SEL_TDATA && !tcmd_q[`BPT_T_CMD]) begin
            tlb_q[{t_wset, tcmd_q[14:12]}].valid <= tcmd_q[`BPT_T_VALID];
            tlb_q[{t_wset, tcmd_q[14:12]}].lin <= tcmd_q[31:12];
            tlb_q[{t_wset, tcmd_q[14:12]}].dirty <= tcmd_q[`BPT_T_DIRTY+1];
            tlb_q[{t_wset, tcmd_q[14:12]}].user <= tcmd_q[`BPT_T_USER+1];
            tlb_q[{t_wset, tcmd_q[14:12]}].writable <= tcmd_q[`BPT_T_WRIT+1];
            tlb_q[{t_wset, tcmd_q[14:12]}].phys <= reg_wdata[31:12];
            tlb_q[{t_wset, tcmd_q[14:12]}].cd <= reg_wdata[`BPT_T_CD];
            tlb_q[{t_wset, tcmd_q[14:12]}].wt <= reg_wdata[`BPT_T_WT];
            plru_q[tcmd_q[14:12]] <= {~t_wset[0] & t_wset[1], ~t_wset[0] & ~t_wset[1], ~t_wset[1]}
                | (plru_q[tcmd_q[14:12]] & {~t_wset[1], t_wset[1], 1'b0});
        end
    end
    // Cache test: operation starts when the control register is written
    logic [1:0] c_op;
    logic [6:0] c_line;
    logic [7:0] c_ent;
    assign c_op = reg_wdata[`BPT_C_OP +: 2];
    assign c_line = reg_wdata[`BPT_C_LINE +: 7];
    assign c_ent = {direct_mapped ? reg_wdata[11] : reg_wdata[`BPT_C_SET], c_line};
    logic c_go;
    assign c_go = clk_en && reg_wr && reg_sel == `BPT_SEL_CCTRL;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int l = 0; l < 2*CACHE_LINES; l++)
                cache_q[l] <= '0;
            for (int l = 0; l < CACHE_LINES; l++)
                recent_q[l] <= 1'b0;
        end else if (c_go) begin
            unique case (c_op)
                `BPT_COP_WRITE: begin
                    cache_q[c_ent].tag <= ctag_q[`BPT_C_TAG +: 23];
                    cache_q[c_ent].bvalid <= ctag_q[`BPT_C_BV +: 4];
                    cache_q[c_ent].data <= cdata_q;
                    if (!direct_mapped)
                        recent_q[c_line] <= c_ent[7];
                end
                `BPT_COP_FLUSH: begin
                    for (int l = 0; l < 2*CACHE_LINES; l++)
                        cache_q[l].bvalid <= 4'h0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cdata_q <= `BPT_ZERO32;
            ctag_q <= `BPT_ZERO32;
            cctrl_q <= `BPT_ZERO32;
        end else if (clk_en) begin
            if (reg_wr && reg_sel == `BPT_SEL_CDATA)
                cdata_q <= reg_wdata;
            if (reg_wr && reg_sel == `BPT_SEL_CTAG)
                ctag_q <= reg_wdata;
            if (c_go)
                cctrl_q <= reg_wdata;
            if (c_go && c_op == `BPT_COP_READ) begin
                cdata_q <= cache_q[c_ent].data;
                ctag_q[`BPT_C_TAG +: 23] <= cache_q[c_ent].tag;
                ctag_q[`BPT_C_REC] <= recent_q[c_line];
                ctag_q[`BPT_C_BV +: 4] <= cache_q[c_ent].bvalid;
            end
        end
    end

    // Register read mux
    always_comb begin
        unique case (reg_sel)
            `BPT_SEL_ADDR0, `BPT_SEL_ADDR1, `BPT_SEL_ADDR2, `BPT_SEL_ADDR3: reg_rdata = bp_addr_q[reg_sel[1:0]];
            `BPT_SEL_STATUS: reg_rdata = status_q;
            `BPT_SEL_CONTROL: reg_rdata = control_q;
            `BPT_SEL_CDATA: reg_rdata = cdata_q;
            `BPT_SEL_CTAG: reg_rdata = ctag_q;
            `BPT_SEL_CCTRL: reg_rdata = cctrl_q;
            `BPT_SEL_TCMD: reg_rdata = tcmd_q[`BPT_T_CMD] ? (tcmd_q | 32'h00000800) : tcmd_q;
            `BPT_SEL_TDATA: reg_rdata = tdata_q;
            default: reg_rdata = `BPT_ZERO32;
        endcase
    end

    step_sets_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && step_fire |=> status_q[`BPT_ST_SSTEP]) else $error("single step flag not set");
    hit_flag_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        debug_exc && bp_hit[0] |=> status_q[0]) else $error("hit flag not set");
    lock_cleared_a: assert property (@(posedge mclk) disable iff (!rstn)
        debug_exc |=> !control_q[`BPT_CT_LOCK]) else $error("lock not cleared");
    local_cleared_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && task_switch |=> control_q[0] == 1'b0) else $error("local enable kept");
    status_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(clk_en && reg_wr && reg_sel == `BPT_SEL_STATUS) && status_q[0] |=> status_q[0])
        else $error("status cleared by hardware");
    enable_gates_a: assert property (@(posedge mclk) disable iff (!rstn)
        !step_fire && bp_hit == 4'h4 && control_q[5:4] == 2'h0 |-> !debug_exc)
        else $error("disabled breakpoint fired");
    tsw_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && task_switch && task_trap_bit |=> status_q[`BPT_ST_TSW]) else $error("task flag missing");
    trap_each_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && insn_done && trap_flag |-> debug_exc) else $error("no trap after insn");

endmodule

`default_nettype wire

/* File: sim/bpt_unit_tb.sv */
// Self-checking testbench for the breakpoint and array test unit.
// Assumes bpt_pkg and bpt_regs.svh are compiled with the design; drives all inputs at falling edges.
`include "bpt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bpt_unit_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_sel = 4'h0;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata;
    bpt_pkg::bpt_access_t acc = '0;
    logic insn_done = 1'b0;
    logic trap_flag = 1'b0;
    logic task_switch = 1'b0;
    logic task_trap_bit = 1'b0;
    logic clk_en = 1'b1;
    logic direct_mapped = 1'b0;
    logic debug_exc;
    logic debug_access_lock;
    int err_count = 0;
    int compares = 0;

    always #50 mclk = ~mclk;

    bpt_unit dut (
        .mclk(mclk), .rstn(rstn), .clk_en(clk_en),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .access(acc), .insn_done(insn_done), .trap_flag(trap_flag),
        .task_switch(task_switch), .task_trap_bit(task_trap_bit), .direct_mapped(direct_mapped),
        .debug_exc(debug_exc), .debug_access_lock(debug_access_lock)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Register move, one cycle strobe
    task automatic wr(input logic [3:0] sel, input logic [31:0] d);
        @(negedge mclk);
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input string name, input logic [3:0] sel, input logic [31:0] exp, input logic [31:0] m);
        @(negedge mclk);
        reg_sel = sel;
        #1;
        cmp(name, exp & m, reg_rdata & m);
    endtask

    // One access for one cycle, exception request looked at while it is present
    task automatic ev(input string name, input logic [31:0] a, input logic [1:0] sz, input logic w,
                      input logic x, input logic exp);
        @(negedge mclk);
        acc.valid = 1'b1;
        acc.addr = a;
        acc.size = sz;
        acc.write = w;
        acc.exec = x;
        #1;
        cmp(name, {31'h0, exp}, {31'h0, debug_exc});
        @(negedge mclk);
        acc.valid = 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        // Reset values and unmapped selector
        rd("status_rst", `BPT_SEL_STATUS, 32'hffff0ff0, 32'hffffffff);
        rd("control_rst", `BPT_SEL_CONTROL, 32'h00000400, 32'hffffffff);
        rd("addr0_rst", `BPT_SEL_ADDR0, 32'h00000000, 32'hffffffff);
        rd("unmapped", 4'h4, 32'h00000000, 32'hffffffff);
        // Four addresses
        wr(`BPT_SEL_ADDR0, 32'h00003000);
        wr(`BPT_SEL_ADDR1, 32'h00001000);
        wr(`BPT_SEL_ADDR2, 32'h00001002);
        wr(`BPT_SEL_ADDR3, 32'h00005000);
        rd("addr0", `BPT_SEL_ADDR0, 32'h00003000, 32'hffffffff);
        rd("addr1", `BPT_SEL_ADDR1, 32'h00001000, 32'hffffffff);
        rd("addr2", `BPT_SEL_ADDR2, 32'h00001002, 32'hffffffff);
        rd("addr3", `BPT_SEL_ADDR3, 32'h00005000, 32'hffffffff);
        // Clock enable low freezes register writes
        @(negedge mclk);
        clk_en = 1'b0;
        wr(`BPT_SEL_ADDR3, 32'h0000dead);
        clk_en = 1'b1;
        rd("addr3_frozen", `BPT_SEL_ADDR3, 32'h00005000, 32'hffffffff);
        // G0 exec 1 byte; L1 write 4 bytes; bp2 disabled rd/wr 1 byte; lock on
        wr(`BPT_SEL_CONTROL, 32'h03d02006);
        rd("control", `BPT_SEL_CONTROL, 32'h03d02406, 32'hffffffff);
        cmp("lock_set", 32'h1, {31'h0, debug_access_lock});
        ev("read_on_write_bp", 32'h00001000, 2'h0, 1'b0, 1'b0, 1'b0);
        ev("exec_on_write_bp", 32'h00001000, 2'h0, 1'b0, 1'b1, 1'b0);
        ev("outside_len", 32'h00001004, 2'h0, 1'b1, 1'b0, 1'b0);
        ev("disabled_bp", 32'h00001002, 2'h0, 1'b0, 1'b0, 1'b0);
        ev("exec_hit", 32'h00003000, 2'h0, 1'b0, 1'b1, 1'b1);
        rd("status_exec", `BPT_SEL_STATUS, 32'hffff0ff1, 32'hffffffff);
        cmp("lock_clr", 32'h0, {31'h0, debug_access_lock});
        repeat (3) @(negedge mclk);
        rd("status_kept", `BPT_SEL_STATUS, 32'hffff0ff1, 32'hffffffff);
        wr(`BPT_SEL_STATUS, 32'h00000000);
        rd("status_swclr", `BPT_SEL_STATUS, 32'hffff0ff0, 32'hffffffff);
        ev("write_hit", 32'h00001002, 2'h0, 1'b1, 1'b0, 1'b1);
        rd("status_write", `BPT_SEL_STATUS, 32'hffff0ff6, 32'hffffffff);
        wr(`BPT_SEL_STATUS, 32'h00000000);
        // Task switch into trapping task
        @(negedge mclk);
        task_switch = 1'b1;
        task_trap_bit = 1'b1;
        @(negedge mclk);
        task_switch = 1'b0;
        task_trap_bit = 1'b0;
        rd("control_tsw", `BPT_SEL_CONTROL, 32'h03d00402, 32'hffffffff);
        rd("status_tsw", `BPT_SEL_STATUS, 32'hffff8ff0, 32'hffffffff);
        wr(`BPT_SEL_STATUS, 32'h00000000);
        // Single step
        @(negedge mclk);
        trap_flag = 1'b1;
        #1;
        cmp("trap_no_insn", 32'h0, {31'h0, debug_exc});
        @(negedge mclk);
        insn_done = 1'b1;
        #1;
        cmp("trap_exc", 32'h1, {31'h0, debug_exc});
        @(negedge mclk);
        insn_done = 1'b0;
        trap_flag = 1'b0;
        rd("status_step", `BPT_SEL_STATUS, 32'hffff4ff0, 32'hffffffff);
        // Translation buffer: placed write into set 2, then lookups
        wr(`BPT_SEL_TCMD, 32'h12345cc0);
        wr(`BPT_SEL_TDATA, 32'habcde818);
        wr(`BPT_SEL_TCMD, 32'h12345fe1);
        rd("tlb_data", `BPT_SEL_TDATA, 32'habcde818, 32'hfffffc1c);
        rd("tlb_attr", `BPT_SEL_TCMD, 32'h12345cc0, 32'hfffffff0);
        wr(`BPT_SEL_TCMD, 32'h12345be1);
        rd("tlb_attr_miss", `BPT_SEL_TDATA, 32'h00000000, 32'h00000010);
        wr(`BPT_SEL_TCMD, 32'h123454c0);
        wr(`BPT_SEL_TDATA, 32'habcde818);
        wr(`BPT_SEL_TCMD, 32'h12345fe1);
        rd("tlb_invalid", `BPT_SEL_TDATA, 32'h00000000, 32'h00000010);
        // Cache: write line 5 set 1, read back, other set, flush, no-op
        wr(`BPT_SEL_CDATA, 32'hdeadbc00);
        wr(`BPT_SEL_CTAG, 32'h91a2b278);
        wr(`BPT_SEL_CCTRL, 32'h00000055);
        wr(`BPT_SEL_CDATA, 32'h00000000);
        wr(`BPT_SEL_CTAG, 32'h00000000);
        wr(`BPT_SEL_CCTRL, 32'h00000056);
        rd("cache_data", `BPT_SEL_CDATA, 32'hdeadbc00, 32'hfffffc00);
        rd("cache_tag", `BPT_SEL_CTAG, 32'h91a2b2f8, 32'hfffffef8);
        wr(`BPT_SEL_CCTRL, 32'h00000052);
        rd("cache_set0", `BPT_SEL_CTAG, 32'h00000000, 32'h00000078);
        wr(`BPT_SEL_CCTRL, 32'h00000003);
        wr(`BPT_SEL_CCTRL, 32'h00000056);
        rd("cache_flush", `BPT_SEL_CTAG, 32'h00000000, 32'h00000078);
        wr(`BPT_SEL_CDATA, 32'h11111c00);
        wr(`BPT_SEL_CCTRL, 32'h00000054);
        rd("cache_noop", `BPT_SEL_CDATA, 32'h11111c00, 32'hfffffc00);
        // Direct mapped: entry bit from bit 11, so set bit 2 no longer reaches the written line
        @(negedge mclk);
        direct_mapped = 1'b1;
        wr(`BPT_SEL_CCTRL, 32'h00000056);
        rd("cache_direct", `BPT_SEL_CTAG, 32'h00000000, 32'hfffffe00);
        direct_mapped = 1'b0;
        report_and_stop();
    end
endmodule

`default_nettype wire
